// ---- design/spi_port_defines.svh ----
// Purpose: constants for the byte-wide spi master/slave port
// Assumes: cpu clock clk_sys at 25 MHz
// Notes: rate_select picks one of four cpu clock dividers
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH
// half bit-time in cpu clocks per rate_select code (div 4/16/64/128)
`define HALF_DIV0 8'h02
`define HALF_DIV1 8'h08
`define HALF_DIV2 8'h20
`define HALF_DIV3 8'h40
`define BITS_PER_BYTE 4'h8
`define DATA_RESET 8'h00
`endif

// ---- design/spi_port_pkg.sv ----
// Purpose: types shared by the spi port
// Assumes: nothing
// Notes: one-hot master sequencer states
package spi_port_pkg;
  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_WAIT = 3'b010,
    M_RUN = 3'b100
  } mstate_e;
endpackage

// ---- design/spi_rx_buffer.sv ----
// Purpose: parallel read buffer for received bytes
// Assumes: one write strobe per completed byte
// Notes: newest byte overwrites an unread one
`timescale 1ns/1ps
`include "spi_port_defines.svh"
module spi_rx_buffer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);
  // registered read data; no flag, an unread byte is simply lost
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= `DATA_RESET;
    else if (wr_en)
      rd_data <= wr_data;
  end
endmodule // spi_rx_buffer

// ---- design/spi_master_slave_port.sv ----
// Purpose: byte-wide spi port, master or slave role
// Assumes: pins are asynchronous; sampled through two flip-flops
// Notes: control bits are plain ports; pulses are one clk_sys wide
// Operation
// - port disabled releases all four pins
// - selected slave drives miso, else released
// - low select clears master role bit
// - forced slave change sets done flag
// - master bit stays clear until rewritten
// - applies with select pin input/quasi mode
// - idle master releases mosi and clock
// - active master drives mosi and clock
// - ignore setting: role bit alone decides
// - phase0 slave write while selected collides
// - phase1 slave works with select held
// - master data write starts the transfer
// - shift register exchanges bytes as ring
// - after eight bits stop and flag
// - write during transfer collides, discarded
// - received byte copied to read buffer
// - collision flag cleared by writing one
// - two-bit rate select divides cpu clock
// - phase picks the sample edge; shifting is always on the trailing edge
// - polarity picks clock idle level
// - bit order picks lsb or msb first
`timescale 1ns/1ps
`include "spi_port_defines.svh"
module spi_master_slave_port
  import spi_port_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic port_enable,
  input wire logic select_pin_ignore,
  input wire logic master_role_set,
  input wire logic master_role_clear,
  input wire logic clock_phase,
  input wire logic clock_polarity,
  input wire logic bit_order,
  input wire logic [1:0] rate_select,
  input wire logic [1:0] select_pin_mode,
  input wire logic data_wr,
  input wire logic [7:0] data_wr_value,
  input wire logic done_clear,
  input wire logic collision_clear,
  input wire logic serial_irq_enable,
  input wire logic select_n_in,
  input wire logic serial_clock_in,
  input wire logic mosi_in,
  input wire logic miso_in,
  output logic master_role_bit,
  output logic transfer_done_flag,
  output logic write_collision_flag,
  output logic serial_irq,
  output logic [7:0] serial_data_reg,
  output logic busy,
  output logic serial_clock_out,
  output logic serial_clock_oe,
  output logic mosi_out,
  output logic mosi_oe,
  output logic miso_out,
  output logic miso_oe,
  output logic select_pin_released
);
  logic [1:0] ss_sync_q, sck_sync_q, mosi_sync_q, miso_sync_q;
  logic ss_n, sck, sck_prev_q, sck_rise, sck_fall;
  logic lead_edge, trail_edge, sel_active, is_master, force_slave;
  mstate_e mstate_q;
  logic [7:0] half_cnt_q, half_len;
  logic [3:0] edge_cnt_q, bit_cnt_q;
  logic [7:0] shift_q;
  logic sck_q, sample_q, s_active_q;
  logic byte_done, mstart, transferring, rx_wr;
  logic [7:0] rx_byte;

  // half bit-time from the rate select code
  function automatic logic [7:0] half_of(input logic [1:0] code);
    case (code)
      2'b00: half_of = `HALF_DIV0;
      2'b01: half_of = `HALF_DIV1;
      2'b10: half_of = `HALF_DIV2;
      default: half_of = `HALF_DIV3;
    endcase
  endfunction

  // next shifter value: out bit leaves, in bit enters by order
  function automatic logic [7:0] shift_in(input logic [7:0] v,
                                          input logic b, input logic lsb);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // pins cross in through two flops before any logic reads them
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ss_sync_q <= 2'b11;
      sck_sync_q <= 2'b00;
      mosi_sync_q <= 2'b00;
      miso_sync_q <= 2'b00;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      ss_sync_q <= {ss_sync_q[0], select_n_in};
      sck_sync_q <= {sck_sync_q[0], serial_clock_in};
      mosi_sync_q <= {mosi_sync_q[0], mosi_in};
      miso_sync_q <= {miso_sync_q[0], miso_in};
      sck_prev_q <= sck_sync_q[1];
    end
  end

  assign ss_n = ss_sync_q[1];
  assign sck = sck_sync_q[1];
  assign sck_rise = sck & ~sck_prev_q;
  assign sck_fall = ~sck & sck_prev_q;
  assign lead_edge = clock_polarity ? sck_fall : sck_rise;
  assign trail_edge = clock_polarity ? sck_rise : sck_fall;
  assign is_master = port_enable & master_role_bit;
  // select pin only counts without ignore
  assign sel_active = select_pin_ignore | ~ss_n;
  // low select in input or quasi mode
  assign force_slave = port_enable & ~select_pin_ignore & master_role_bit
                       & ~ss_n & ~select_pin_mode[1];
  assign mstart = is_master & data_wr & (mstate_q == M_IDLE)
                  & ~force_slave;
  assign transferring = (mstate_q != M_IDLE) | s_active_q;
  // divider length shared by the sequencer and the tick strobes
  assign half_len = half_of(rate_select);

  // role bit cleared by select, set only by software
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      master_role_bit <= 1'b0;
    else if (force_slave)
      master_role_bit <= 1'b0;
    else if (master_role_set)
      master_role_bit <= 1'b1;
    else if (master_role_clear)
      master_role_bit <= 1'b0;
  end

  // master sequencer: wait half a bit, then toggle clock 16 times
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mstate_q <= M_IDLE;
      half_cnt_q <= 8'h00;
      edge_cnt_q <= 4'h0;
      sck_q <= 1'b0;
    end
    else
    begin
      case (mstate_q)
        M_IDLE:
        begin
          sck_q <= clock_polarity;
          edge_cnt_q <= 4'h0;
          half_cnt_q <= 8'h00;
          if (mstart)
            mstate_q <= M_WAIT;
        end
        M_WAIT:
        begin
          if (!is_master)
            mstate_q <= M_IDLE;
          else if (half_cnt_q == half_len - 8'h01)
          begin
            half_cnt_q <= 8'h00;
            mstate_q <= M_RUN;
          end
          else
            half_cnt_q <= half_cnt_q + 8'h01;
        end
        M_RUN:
        begin
          if (!is_master)
            mstate_q <= M_IDLE;
          else if (half_cnt_q == half_len - 8'h01)
          begin
            half_cnt_q <= 8'h00;
            sck_q <= ~sck_q;
            edge_cnt_q <= edge_cnt_q + 4'h1;
            // sixteen edges make eight bits, then stop
            if (edge_cnt_q == 4'hf)
              mstate_q <= M_IDLE;
          end
          else
            half_cnt_q <= half_cnt_q + 8'h01;
        end
        default: mstate_q <= M_IDLE;
      endcase
    end
  end

  // master edge strobes on the internal clock toggles
  logic m_tick, m_lead, m_trail;
  assign m_tick = (mstate_q == M_RUN) & (half_cnt_q == half_len - 8'h01);
  assign m_lead = m_tick & ~edge_cnt_q[0];
  assign m_trail = m_tick & edge_cnt_q[0];

  // slave byte tracking; phase 0 restarts on each select
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s_active_q <= 1'b0;
    else if (is_master || !port_enable || !sel_active || byte_done)
      s_active_q <= 1'b0;
    else if (lead_edge)
      s_active_q <= 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_q <= `DATA_RESET;
      sample_q <= 1'b0;
      bit_cnt_q <= 4'h0;
    end
    else if (mstart || (!is_master && data_wr && !transferring
                        && !(sel_active && !clock_phase)))
    begin
      // load at start; a slave load is ready before first edge
      shift_q <= data_wr_value;
      bit_cnt_q <= 4'h0;
    end
    else if (!port_enable || (!is_master && !sel_active))
      bit_cnt_q <= 4'h0;
    else
    begin
      // sample on the phase-picked edge, shift on the trailing edge in both phases
      if ((is_master ? m_lead : lead_edge) != clock_phase
          && (is_master ? (m_lead | m_trail) : (lead_edge | trail_edge)))
        sample_q <= is_master ? miso_sync_q[1] : mosi_sync_q[1];
      if (!clock_phase ? (is_master ? m_trail : trail_edge)
                       : (is_master ? m_trail : trail_edge))
      begin
        shift_q <= shift_in(shift_q, is_master ? (clock_phase
                   ? miso_sync_q[1] : sample_q) : (clock_phase
                   ? mosi_sync_q[1] : sample_q), bit_order);
        bit_cnt_q <= (bit_cnt_q == `BITS_PER_BYTE - 4'h1)
                     ? 4'h0 : bit_cnt_q + 4'h1;
      end
    end
  end

  assign byte_done = port_enable & (is_master ? (m_trail
                     & edge_cnt_q == 4'hf) : (trail_edge & sel_active
                     & bit_cnt_q == `BITS_PER_BYTE - 4'h1));
  assign rx_byte = shift_in(shift_q, is_master ? (clock_phase
                   ? miso_sync_q[1] : sample_q) : (clock_phase
                   ? mosi_sync_q[1] : sample_q), bit_order);
  assign rx_wr = byte_done;

  // completed byte goes to the read buffer
  spi_rx_buffer u_rx (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(rx_wr),
    .wr_data(rx_byte),
    .rd_data(serial_data_reg)
  );

  // done flag; set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      transfer_done_flag <= 1'b0;
    else if (byte_done || force_slave)
      transfer_done_flag <= 1'b1;
    else if (done_clear)
      transfer_done_flag <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      write_collision_flag <= 1'b0;
    else if (data_wr && port_enable && (transferring
             || (!is_master && !clock_phase && !ss_n
                 && !select_pin_ignore)))
      write_collision_flag <= 1'b1;
    else if (collision_clear)
      write_collision_flag <= 1'b0;
  end

  // interrupt request follows flag and enable
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      serial_irq <= 1'b0;
    else
      serial_irq <= (byte_done | force_slave | transfer_done_flag)
                    & serial_irq_enable;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_clock_out <= 1'b0;
      serial_clock_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      select_pin_released <= 1'b1;
      busy <= 1'b0;
    end
    else
    begin
      serial_clock_out <= sck_q;
      serial_clock_oe <= is_master & (mstate_q == M_RUN);
      mosi_out <= bit_order ? shift_q[0] : shift_q[7];
      mosi_oe <= is_master & (mstate_q == M_RUN);
      miso_out <= bit_order ? shift_q[0] : shift_q[7];
      miso_oe <= port_enable & ~is_master & sel_active & ~force_slave;
      select_pin_released <= ~port_enable | select_pin_ignore;
      busy <= transferring;
    end
  end
endmodule // spi_master_slave_port

// ---- bench/spi_port_monitor.sv ----
// Purpose: port-level checks of the spi port
// Assumes: one clock domain, async active-low reset
// Notes: latencies allow for the two-flop pin synchronizers
`timescale 1ns/1ps
module spi_port_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic port_enable,
  input wire logic select_pin_ignore,
  input wire logic master_role_set,
  input wire logic data_wr,
  input wire logic done_clear,
  input wire logic collision_clear,
  input wire logic serial_irq_enable,
  input wire logic select_n_in,
  input wire logic master_role_bit,
  input wire logic transfer_done_flag,
  input wire logic write_collision_flag,
  input wire logic serial_irq,
  input wire logic busy,
  input wire logic serial_clock_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic [1:0] select_pin_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // pin ownership per mode
  a_off_pins_free: assert property (
    !port_enable [*4] |-> !(mosi_oe || serial_clock_oe || miso_oe))
    else $error("pin driven while disabled");
  a_unselected_miso_free: assert property (
    (port_enable && !select_pin_ignore && !master_role_bit && select_n_in)
    [*4] |-> !miso_oe) else $error("miso driven while unselected");
  a_idle_master_quiet: assert property (
    !busy [*2] |-> !mosi_oe && !serial_clock_oe)
    else $error("idle port drives mosi or clock");
  // role bit handling; sync delay bounds the wait
  a_select_clears_role: assert property (
    port_enable && !select_pin_ignore && master_role_bit && !select_n_in
    && !select_pin_mode[1] |-> ##[1:4] !master_role_bit)
    else $error("role bit kept under low select");
  a_role_needs_set: assert property (
    $rose(master_role_bit) |-> $past(master_role_set)
    || $past(master_role_set, 2)) else $error("role bit set by itself");
  // flags and interrupt
  a_end_sets_done: assert property (
    $fell(serial_clock_oe) |-> ##[0:2] transfer_done_flag)
    else $error("done flag missing after byte");
  a_done_sticky: assert property (
    transfer_done_flag && !done_clear |=> transfer_done_flag)
    else $error("done flag dropped");
  a_busy_write_collides: assert property (
    busy && data_wr |-> ##[1:2] write_collision_flag)
    else $error("no collision on busy write");
  a_collision_sticky: assert property (
    write_collision_flag && !collision_clear |=> write_collision_flag)
    else $error("collision flag dropped");
  a_irq_follows_flag: assert property (
    transfer_done_flag && serial_irq_enable && !done_clear |=> serial_irq)
    else $error("interrupt missing");
endmodule // spi_port_monitor
bind spi_master_slave_port spi_port_monitor u_monitor (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .port_enable(port_enable),
  .select_pin_ignore(select_pin_ignore),
  .master_role_set(master_role_set),
  .data_wr(data_wr),
  .done_clear(done_clear),
  .collision_clear(collision_clear),
  .serial_irq_enable(serial_irq_enable),
  .select_n_in(select_n_in),
  .master_role_bit(master_role_bit),
  .transfer_done_flag(transfer_done_flag),
  .write_collision_flag(write_collision_flag),
  .serial_irq(serial_irq),
  .busy(busy),
  .serial_clock_oe(serial_clock_oe),
  .mosi_oe(mosi_oe),
  .miso_oe(miso_oe),
  .select_pin_mode(select_pin_mode)
);

// ---- bench/spi_far_slave.sv ----
// Purpose: behavioural spi slave on the far side
// Assumes: phase 0, polarity 0, msb first
// Notes: released miso shows the inverse of its last bit
`timescale 1ns/1ps
module spi_far_slave (
  input wire logic sck,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  logic [7:0] sr;
  logic in_bit = 1'b0;
  logic last = 1'b0;
  always @(negedge sel_n) sr = tx_byte;
  always @(posedge sck) if (!sel_n) in_bit = mosi;
  // shift on trailing edge, one byte per select
  always @(negedge sck)
    if (!sel_n)
    begin
      last = sr[7];
      sr = {sr[6:0], in_bit};
    end
  assign rx_byte = sr;
  assign miso = sel_n ? ~last : sr[7];
endmodule // spi_far_slave

// ---- bench/tb.sv ----
// Purpose: self-checking bench for the spi port
// Assumes: far slave in phase 0, polarity 0
// Notes: inputs change on the falling clock edge
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic port_enable = 1'b0, select_pin_ignore = 1'b0, master_role_set = 1'b0;
  logic master_role_clear = 1'b0, clock_phase = 1'b0, clock_polarity = 1'b0;
  logic bit_order = 1'b0, data_wr = 1'b0, done_clear = 1'b0;
  logic collision_clear = 1'b0, serial_irq_enable = 1'b0, select_n_in = 1'b1;
  logic serial_clock_in = 1'b0, mosi_in = 1'b0, miso_in, far_sel_n = 1'b1;
  logic [1:0] rate_select = 2'b00, select_pin_mode = 2'b00;
  logic [7:0] data_wr_value = 8'h00, far_tx = 8'h00, far_rx, serial_data_reg;
  logic master_role_bit, transfer_done_flag, write_collision_flag, serial_irq;
  logic busy, serial_clock_out, serial_clock_oe, mosi_out, mosi_oe, miso_out;
  logic miso_oe, select_pin_released, sck_w, mosi_w;
  int error_cnt = 0;
  int comparisons = 0;
  // clock pulled low when released, as polarity 0 needs
  assign sck_w = serial_clock_oe ? serial_clock_out : 1'b0;
  assign mosi_w = mosi_oe ? mosi_out : 1'b1;
  spi_master_slave_port u_dut (.*);
  spi_far_slave u_far (.sck(sck_w), .sel_n(far_sel_n), .mosi(mosi_w),
    .tx_byte(far_tx), .miso(miso_in), .rx_byte(far_rx));
  always #20 clk_sys = ~clk_sys;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      rev[i] = v[7-i];
  endfunction
  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one master byte; a second write lands before its first clock edge
  task automatic t_master(input logic bo);
    int n;
    @(negedge clk_sys);
    port_enable = 1'b1;
    select_pin_ignore = 1'b1;
    bit_order = bo;
    rate_select = 2'b01;
    pulse(master_role_set);
    far_tx = 8'h3C;
    far_sel_n = 1'b0;
    data_wr_value = 8'hA5;
    pulse(data_wr);
    repeat (3) @(negedge clk_sys);
    check(mosi_oe, 1'b0);
    repeat (8) @(negedge clk_sys);
    check({mosi_oe, serial_clock_oe}, 2'b11);
    data_wr_value = 8'hFF;
    pulse(data_wr);
    n = 0;
    while (transfer_done_flag !== 1'b1 && n < 400)
    begin
      @(negedge clk_sys);
      n++;
    end
    // far slave takes its last bit on the pin fall, a clock later
    repeat (2) @(negedge clk_sys);
    check(transfer_done_flag, 1'b1);
    check(far_rx, bo ? rev(8'hA5) : 8'hA5);
    check(serial_data_reg, bo ? rev(8'h3C) : 8'h3C);
    check(write_collision_flag, 1'b1);
    check(select_pin_released, 1'b1);
    far_sel_n = 1'b1;
    pulse(collision_clear);
    pulse(done_clear);
    check({write_collision_flag, mosi_oe}, 2'b00);
    pulse(master_role_clear);
    check(master_role_bit, 1'b0);
  endtask
  // one byte as external master, polarity 1, phase 1, msb first
  task automatic slave_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      // leading edge: next bit goes out
      serial_clock_in = 1'b0;
      mosi_in = tx[i];
      repeat (8) @(negedge clk_sys);
      // trailing edge: take the slave's bit
      serial_clock_in = 1'b1;
      rx[i] = miso_out;
      repeat (8) @(negedge clk_sys);
    end
  endtask
  // slave, phase 1, two bytes with select held low
  task automatic t_slave();
    logic [7:0] got;
    @(negedge clk_sys);
    bit_order = 1'b0;
    clock_phase = 1'b1;
    clock_polarity = 1'b1;
    serial_clock_in = 1'b1;
    data_wr_value = 8'h96;
    pulse(data_wr);
    select_n_in = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(miso_oe, 1'b1);
    slave_byte(8'h5A, got);
    check(got, 8'h96);
    check(serial_data_reg, 8'h5A);
    check(transfer_done_flag, 1'b1);
    data_wr_value = 8'hC3;
    pulse(data_wr);
    slave_byte(8'h0F, got);
    check(got, 8'hC3);
    check(serial_data_reg, 8'h0F);
    check(write_collision_flag, 1'b0);
    select_n_in = 1'b1;
    pulse(done_clear);
  endtask
  // forced fall to slave, then a selected slave write
  task automatic t_forced(input logic [1:0] md);
    @(negedge clk_sys);
    select_pin_ignore = 1'b0;
    select_pin_mode = md;
    serial_irq_enable = 1'b1;
    pulse(master_role_set);
    select_n_in = 1'b0;
    repeat (5) @(negedge clk_sys);
    check(master_role_bit, 1'b0);
    check({transfer_done_flag, serial_irq}, 2'b11);
    check(miso_oe, 1'b1);
    pulse(data_wr);
    repeat (2) @(negedge clk_sys);
    check(write_collision_flag, 1'b1);
    select_n_in = 1'b1;
    repeat (5) @(negedge clk_sys);
    check({master_role_bit, miso_oe}, 2'b00);
    pulse(collision_clear);
    pulse(done_clear);
  endtask
  // selected slave, then port switched off
  task automatic t_disable();
    select_n_in = 1'b0;
    port_enable = 1'b0;
    repeat (5) @(negedge clk_sys);
    check({miso_oe, mosi_oe, serial_clock_oe}, 3'b000);
  endtask
  initial
  begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    check(select_pin_released, 1'b1);
    t_master(1'b0);
    t_master(1'b1);
    t_forced(2'b00);
    t_forced(2'b01);
    t_slave();
    t_disable();
    stop_test();
  end
  // watchdog, far beyond the roughly 600 cycles needed
  initial
  begin
    #400_000;
    error_cnt++;
    stop_test();
  end
endmodule // tb
